// >>> design/csi_regs.vh
`ifndef CSI_REGS_VH
`define CSI_REGS_VH

// Byte addresses on the register bus
`define CSI_ADDR_CON1 8'h00
`define CSI_ADDR_CON2 8'h04
`define CSI_ADDR_DIV 8'h08
`define CSI_ADDR_STAT 8'h0C
`define CSI_ADDR_RXSLOT 8'h10
`define CSI_ADDR_TXSLOT 8'h14
// Buffer pages: address bits 7:4, word select in bits 3:2
`define CSI_PAGE_RXBUF 4'h2
`define CSI_PAGE_TXBUF 4'h3

`define CSI_REG_RESET 16'h0000
`define CSI_CON1_MASK 16'hAFE3
`define CSI_CON2_MASK 16'h0DEF
`define CSI_DIV_MASK 16'h0FFF

// Control one fields
`define CSI_ON 15
`define CSI_IDLE_HALT 13
`define CSI_LOOP 11
`define CSI_CLK_DIR 10
`define CSI_CLK_EDGE 9
`define CSI_FS_DIR 8
`define CSI_UNDER_REP 7
`define CSI_IDLE_OUT 6
`define CSI_JUSTIFY 5
`define CSI_FMT 1:0

// Control two and divider fields
`define CSI_WPI 11:10
`define CSI_FWC 8:5
`define CSI_WB 3:0
`define CSI_DIVISOR 11:0

// Frame formats
`define CSI_FMT_MULTI 2'h0
`define CSI_FMT_I2S 2'h1
`define CSI_FMT_AC16 2'h2
`define CSI_FMT_AC20 2'h3

// Slot geometry
`define CSI_AC_LAST_SLOT 4'hC
`define CSI_I2S_LAST_SLOT 4'h1
`define CSI_AC_TAG_BITS 5'h10
`define CSI_AC_SLOT_BITS 5'h14
`define CSI_FULL_BITS 5'h10

`endif

// >>> design/csi_sync.v
`timescale 1ns/1ps
`default_nettype none
module csi_sync #(
  parameter W = 3
) (
  input wire mclk,
  input wire arst_n,
  input wire clkEn,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta_q;

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= {W{1'b0}};
      q <= {W{1'b0}};
    end else if (clkEn) begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule
`default_nettype wire

// >>> design/csi_buf_mem.v
`timescale 1ns/1ps
`default_nettype none
// Two write and two read ports; callers keep the write addresses apart
module csi_buf_mem #(
  parameter AW = 4,
  parameter DW = 16
) (
  input wire mclk,
  input wire clkEn,
  input wire wrEnA,
  input wire [AW-1:0] wrAddrA,
  input wire [DW-1:0] wrDataA,
  input wire wrEnB,
  input wire [AW-1:0] wrAddrB,
  input wire [DW-1:0] wrDataB,
  input wire [AW-1:0] rdAddrA,
  output reg [DW-1:0] rdDataA,
  input wire [AW-1:0] rdAddrB,
  output reg [DW-1:0] rdDataB
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge mclk) begin
    if (clkEn) begin
      if (wrEnA) begin
        mem[wrAddrA] <= wrDataA;
      end
      if (wrEnB) begin
        mem[wrAddrB] <= wrDataB;
      end
      rdDataA <= mem[rdAddrA];
      rdDataB <= mem[rdAddrB];
    end
  end
endmodule
`default_nettype wire

// >>> design/csi_core.v
// Notes on behaviour
// - One 16-bit shift register moves data both ways, most significant bit first.
// - A 2-bit word pointer with a direction prefix addresses the shadow words.
// - Nothing runs unless the module enable bit is set.
// - With idle halt set, the interface stops while the processor idles.
// - Loopback feeds the serial output straight back to the serial input.
// - Clock direction one takes bit clock from outside, zero drives it.
// - Edge control picks which bit clock edge changes and which samples data.
// - Frame sync direction one takes frame sync from outside, zero drives it.
// - On underflow send the last written transmit value or zeros.
// - Disabled transmit slots tri-state the output or drive zeros.
// - Justify one puts the first bit in the frame sync period.
// - Format field picks multi-channel, I2S, 16-bit or 20-bit AC-link.
// - Words per interrupt is the field value plus one.
// - Words per frame is the field value plus one.
// - Word length in bits is the field value plus one.
// - Status shows the active slot number.
// - Receive overflow flag is sticky once a receive block was overrun.
// - Receive full flag shows new receive data not yet read.
// - Transmit underflow flag is sticky once a transmit block was missing.
// - Transmit empty flag shows the transmit registers need refilling.
// - Each slot's receive enable decides whether its input is kept.
// - Each slot's transmit enable decides whether buffer data is sent.
// - Received words are left aligned with zero low bits; short sends drop LSBs.
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "csi_regs.vh"
module csi_core #(
  parameter DW = 16,
  parameter PW = 2
) (
  input wire mclk,
  input wire arst_n,
  input wire clkEn,
  input wire cpuIdle,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire bitClkIn,
  output reg bitClkOut,
  output reg bitClkOe,
  input wire frameSyncIn,
  output reg frameSyncOut,
  output reg frameSyncOe,
  input wire serialInPin,
  output reg serialOutPin,
  output reg serialOutOe,
  output reg blockDone
);
  reg [15:0] con1_q, con2_q, div_q, rxSlotOn_q, txSlotOn_q;
  reg [11:0] divCnt_q;
  reg prevClk_q, fsPrev_q;
  reg started_q, lead_q;
  reg [3:0] slot_q;
  reg [4:0] wordBit_q;
  reg [DW-1:0] sr_q;
  reg [PW-1:0] ptr_q;
  reg bank_q;
  reg rxFull_q, rxOver_q, txUnder_q, txEmpty_q, txFilled_q, underBlock_q;
  reg [DW-1:0] lastTx_q;
  reg waitDone_q;
  wire [2:0] pinSync;
  wire [DW-1:0] memRdSer, memRdBus;

  wire on = con1_q[`CSI_ON];
  wire run = on & ~(con1_q[`CSI_IDLE_HALT] & cpuIdle);
  wire clkDir = con1_q[`CSI_CLK_DIR];
  wire fsDir = con1_q[`CSI_FS_DIR];
  wire justify = con1_q[`CSI_JUSTIFY];
  wire idleOut = con1_q[`CSI_IDLE_OUT];
  wire [1:0] fmt = con1_q[`CSI_FMT];
  wire [1:0] wpi = con2_q[`CSI_WPI];
  wire syncClk = pinSync[0];
  wire syncFs = pinSync[1];
  wire din = con1_q[`CSI_LOOP] ? serialOutPin : pinSync[2];

  csi_sync #(.W(3)) uSync (
    .mclk(mclk),
    .arst_n(arst_n),
    .clkEn(clkEn),
    .d({serialInPin, frameSyncIn, bitClkIn}),
    .q(pinSync)
  );

  // Bit clock edges, found on mclk from the chosen source
  wire bclk = clkDir ? syncClk : bitClkOut;
  wire rise = run & bclk & ~prevClk_q;
  wire fall = run & ~bclk & prevClk_q;
  wire shiftEdge = con1_q[`CSI_CLK_EDGE] ? fall : rise;
  wire sampleEdge = con1_q[`CSI_CLK_EDGE] ? rise : fall;

  // Word and frame geometry
  reg [4:0] wordLen;
  reg [3:0] lastSlot;
  always @* begin
    case (fmt)
      `CSI_FMT_AC16: begin
        wordLen = `CSI_AC_TAG_BITS;
        lastSlot = `CSI_AC_LAST_SLOT;
      end
      `CSI_FMT_AC20: begin
        wordLen = (slot_q == 4'h0) ? `CSI_AC_TAG_BITS : `CSI_AC_SLOT_BITS;
        lastSlot = `CSI_AC_LAST_SLOT;
      end
      `CSI_FMT_I2S: begin
        wordLen = {1'b0, con2_q[`CSI_WB]} + 5'h01;
        lastSlot = `CSI_I2S_LAST_SLOT;
      end
      default: begin
        wordLen = {1'b0, con2_q[`CSI_WB]} + 5'h01;
        lastSlot = con2_q[`CSI_FWC];
      end
    endcase
  end

  wire lastWord = (wordBit_q == wordLen - 5'h01);
  wire lastFrame = started_q & ~lead_q & lastWord & (slot_q == lastSlot);
  wire inData = started_q & ~lead_q & ~wordBit_q[4];
  wire fsHit = sampleEdge & fsDir &
    ((fmt == `CSI_FMT_I2S) ? (~syncFs & fsPrev_q) : (syncFs & ~fsPrev_q));

  // Next period's position, taken at each shift edge
  reg nLead, nLoad;
  reg [3:0] nSlot;
  reg [4:0] nBit;
  always @* begin
    nLead = lead_q;
    nSlot = slot_q;
    nBit = wordBit_q;
    nLoad = 1'b0;
    if (~started_q | lastFrame) begin
      if (justify) begin
        nLead = 1'b0;
        nSlot = 4'h0;
        nBit = 5'h00;
        nLoad = 1'b1;
      end else begin
        nLead = 1'b1;
      end
    end else if (lead_q) begin
      nLead = 1'b0;
      nSlot = 4'h0;
      nBit = 5'h00;
      nLoad = 1'b1;
    end else if (lastWord) begin
      nSlot = slot_q + 4'h1;
      nBit = 5'h00;
      nLoad = 1'b1;
    end else begin
      nBit = wordBit_q + 5'h01;
    end
  end

  // Generated frame sync level for the coming period
  reg fsNext;
  always @* begin
    case (fmt)
      `CSI_FMT_MULTI: fsNext = justify ? (~nLead & (nSlot == 4'h0) & (nBit == 5'h00)) : nLead;
      `CSI_FMT_I2S: fsNext = ~nLead & nSlot[0];
      default: fsNext = nLead | (nSlot == 4'h0);
    endcase
  end

  // Block accounting: pointer and bank move on the completing sample edge
  wire wordDone = sampleEdge & ~fsHit & started_q & ~lead_q & lastWord;
  wire rxOn = rxSlotOn_q[slot_q];
  wire countWord = wordDone & (rxOn | txSlotOn_q[slot_q]);
  wire blockEnd = countWord & (ptr_q == wpi);
  wire [PW-1:0] ptrNext = blockEnd ? {PW{1'b0}} : (countWord ? ptr_q + 1'b1 : ptr_q);
  wire bankNext = blockEnd ? ~bank_q : bank_q;

  // Received word, left aligned with zeroed low bits
  wire [4:0] shAmt = `CSI_FULL_BITS - wordLen;
  wire [DW-1:0] rxShifted = {sr_q[DW-2:0], din};
  wire [DW-1:0] rxWord = wordLen[4] & (wordLen != `CSI_FULL_BITS) ? sr_q : rxShifted << shAmt;
  wire [DW-1:0] txWord = underBlock_q ?
    (con1_q[`CSI_UNDER_REP] ? lastTx_q : {DW{1'b0}}) : memRdSer;

  // Register bus decode
  wire aligned = (paddr[1:0] == 2'h0);
  wire isRxBuf = aligned & (paddr[7:4] == `CSI_PAGE_RXBUF);
  wire isTxBuf = aligned & (paddr[7:4] == `CSI_PAGE_TXBUF);
  wire isReg = aligned & ((paddr == `CSI_ADDR_CON1) | (paddr == `CSI_ADDR_CON2) |
    (paddr == `CSI_ADDR_DIV) | (paddr == `CSI_ADDR_STAT) |
    (paddr == `CSI_ADDR_RXSLOT) | (paddr == `CSI_ADDR_TXSLOT));
  wire mapped = isReg | isRxBuf | isTxBuf;
  wire capture = psel & penable & waitDone_q & ~pready;
  wire doWrite = psel & penable & pready & pwrite & ~pslverr;
  wire swRxRead = capture & ~pwrite & isRxBuf;
  wire statRead = capture & ~pwrite & (paddr == `CSI_ADDR_STAT);
  wire swTxWrite = doWrite & isTxBuf;

  csi_buf_mem #(.AW(PW + 2), .DW(DW)) uMem (
    .mclk(mclk),
    .clkEn(clkEn),
    .wrEnA(wordDone & rxOn),
    .wrAddrA({bank_q, 1'b0, ptr_q}),
    .wrDataA(rxWord),
    .wrEnB(swTxWrite),
    .wrAddrB({~bank_q, 1'b1, paddr[3:2]}),
    .wrDataB(pwdata[DW-1:0]),
    .rdAddrA({bankNext, 1'b1, ptrNext}),
    .rdDataA(memRdSer),
    .rdAddrB({~bank_q, paddr[4], paddr[3:2]}),
    .rdDataB(memRdBus)
  );

  reg [15:0] rdMux;
  always @* begin
    rdMux = 16'h0000;
    if (isRxBuf | isTxBuf) begin
      rdMux = memRdBus;
    end else begin
      case (paddr)
        `CSI_ADDR_CON1: rdMux = con1_q;
        `CSI_ADDR_CON2: rdMux = con2_q;
        `CSI_ADDR_DIV: rdMux = div_q;
        `CSI_ADDR_STAT: rdMux = {4'h0, slot_q, 4'h0, rxOver_q, rxFull_q, txUnder_q, txEmpty_q};
        `CSI_ADDR_RXSLOT: rdMux = rxSlotOn_q;
        `CSI_ADDR_TXSLOT: rdMux = txSlotOn_q;
        default: rdMux = 16'h0000;
      endcase
    end
  end

  // Bus slave: pready rises two cycles after the setup cycle
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      waitDone_q <= 1'b0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      con1_q <= `CSI_REG_RESET;
      con2_q <= `CSI_REG_RESET;
      div_q <= `CSI_REG_RESET;
      rxSlotOn_q <= `CSI_REG_RESET;
      txSlotOn_q <= `CSI_REG_RESET;
      lastTx_q <= `CSI_REG_RESET;
    end else if (clkEn) begin
      waitDone_q <= psel & ~pready;
      pready <= capture;
      if (capture) begin
        pslverr <= ~mapped;
        prdata <= pwrite ? 32'h00000000 : {16'h0000, rdMux};
      end
      if (doWrite) begin
        case (paddr)
          `CSI_ADDR_CON1: con1_q <= pwdata[15:0] & `CSI_CON1_MASK;
          `CSI_ADDR_CON2: con2_q <= pwdata[15:0] & `CSI_CON2_MASK;
          `CSI_ADDR_DIV: div_q <= pwdata[15:0] & `CSI_DIV_MASK;
          `CSI_ADDR_RXSLOT: rxSlotOn_q <= pwdata[15:0];
          `CSI_ADDR_TXSLOT: txSlotOn_q <= pwdata[15:0];
          default: con1_q <= con1_q;
        endcase
        if (isTxBuf) begin
          lastTx_q <= pwdata[DW-1:0];
        end
      end
    end
  end

  // Bit clock generator and pin enables
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      divCnt_q <= 12'h000;
      bitClkOut <= 1'b0;
      bitClkOe <= 1'b0;
      frameSyncOe <= 1'b0;
      prevClk_q <= 1'b0;
    end else if (clkEn) begin
      bitClkOe <= on & ~clkDir;
      frameSyncOe <= on & ~fsDir;
      prevClk_q <= bclk;
      if (run & ~clkDir) begin
        if (divCnt_q == div_q[`CSI_DIVISOR]) begin
          divCnt_q <= 12'h000;
          bitClkOut <= ~bitClkOut;
        end else begin
          divCnt_q <= divCnt_q + 12'h001;
        end
      end else begin
        divCnt_q <= 12'h000;
        bitClkOut <= 1'b0;
      end
    end
  end

  // Frame sequencer, shift register and serial output
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      started_q <= 1'b0;
      lead_q <= 1'b0;
      slot_q <= 4'h0;
      wordBit_q <= 5'h00;
      sr_q <= {DW{1'b0}};
      fsPrev_q <= 1'b0;
      frameSyncOut <= 1'b0;
      serialOutPin <= 1'b0;
      serialOutOe <= 1'b0;
    end else if (clkEn) begin
      if (!run) begin
        started_q <= 1'b0;
        lead_q <= 1'b0;
        slot_q <= 4'h0;
        wordBit_q <= 5'h00;
        frameSyncOut <= 1'b0;
        serialOutPin <= 1'b0;
        serialOutOe <= 1'b0;
      end else if (shiftEdge) begin
        started_q <= 1'b1;
        lead_q <= nLead;
        slot_q <= nSlot;
        wordBit_q <= nBit;
        frameSyncOut <= fsNext;
        if (nLoad) begin
          sr_q <= txWord;
        end
        if (nLead) begin
          serialOutPin <= 1'b0;
          serialOutOe <= ~idleOut;
        end else if (txSlotOn_q[nSlot]) begin
          serialOutPin <= nLoad ? txWord[DW-1] : (~nBit[4] & sr_q[DW-1]);
          serialOutOe <= 1'b1;
        end else begin
          serialOutPin <= 1'b0;
          serialOutOe <= ~idleOut;
        end
      end else if (sampleEdge) begin
        fsPrev_q <= syncFs;
        if (inData) begin
          sr_q <= rxShifted;
        end
        if (fsHit) begin
          // External frame sync realigns the free-running frame counters
          started_q <= 1'b1;
          lead_q <= ~justify;
          if (justify) begin
            slot_q <= 4'h0;
            wordBit_q <= 5'h00;
          end
        end
      end
    end
  end

  // Pointer, bank swap and status flags; a hardware set wins over a clear
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ptr_q <= {PW{1'b0}};
      bank_q <= 1'b0;
      rxFull_q <= 1'b0;
      rxOver_q <= 1'b0;
      txUnder_q <= 1'b0;
      txEmpty_q <= 1'b0;
      txFilled_q <= 1'b0;
      underBlock_q <= 1'b1;
      blockDone <= 1'b0;
    end else if (clkEn) begin
      if (!run) begin
        ptr_q <= {PW{1'b0}};
      end else begin
        ptr_q <= ptrNext;
      end
      bank_q <= bankNext;
      blockDone <= blockEnd;
      rxFull_q <= (rxFull_q & ~swRxRead) | blockEnd;
      rxOver_q <= (rxOver_q & ~statRead) | (blockEnd & rxFull_q);
      txUnder_q <= (txUnder_q & ~statRead) | (blockEnd & ~txFilled_q);
      txEmpty_q <= (txEmpty_q & ~swTxWrite) | blockEnd;
      txFilled_q <= (txFilled_q | swTxWrite) & ~blockEnd;
      if (blockEnd) begin
        underBlock_q <= ~txFilled_q;
      end
    end
  end
endmodule
`default_nettype wire

// >>> dv/csi_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module csi_asserts (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic cpuIdle,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic bitClkOut,
  input wire logic bitClkOe,
  input wire logic frameSyncOe,
  input wire logic frameSyncOut,
  input wire logic serialOutPin,
  input wire logic serialOutOe,
  input wire logic blockDone
);
  logic [15:0] con_q;
  logic [15:0] txSlot_q;
  logic [3:0] age_q;
  logic idle_q;
  wire logic wrDone = psel && penable && pready && pwrite;
  // Pin checks wait for the setup to stand a while, as outputs follow a few cycles late
  wire logic settled = (age_q == 4'hF);
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      con_q <= 16'h0000;
      txSlot_q <= 16'h0000;
      age_q <= 4'h0;
      idle_q <= 1'b0;
    end else begin
      idle_q <= cpuIdle;
      if (wrDone && paddr == 8'h00) con_q <= pwdata[15:0];
      if (wrDone && paddr == 8'h14) txSlot_q <= pwdata[15:0];
      if (wrDone || cpuIdle != idle_q) age_q <= 4'h0;
      else if (age_q != 4'hF) age_q <= age_q + 4'h1;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence setupS;
    psel && !penable;
  endsequence
  sequence answerS;
    !pready ##1 pready;
  endsequence
  bus_answer_a: assert property (setupS |=> answerS)
    else $error("bus answer late");
  off_quiet_a: assert property (!con_q[15] [*4] |-> !bitClkOe && !frameSyncOe && !serialOutOe
    && !frameSyncOut && !serialOutPin) else $error("pins driven while off");
  clk_dir_a: assert property (settled && con_q[15] |-> bitClkOe == !con_q[10])
    else $error("bit clock direction wrong");
  fs_dir_a: assert property (settled && con_q[15] |-> frameSyncOe == !con_q[8])
    else $error("frame sync direction wrong");
  idle_zero_a: assert property (settled && con_q[15] && !con_q[6] && txSlot_q == 16'h0000
    |-> !serialOutPin) else $error("disabled slot not zero");
  idle_float_a: assert property (settled && con_q[15] && con_q[6] && txSlot_q == 16'h0000
    |-> !serialOutOe) else $error("disabled slot driven");
  shift_edge_a: assert property (settled && con_q[15] && !con_q[10] && $changed(serialOutPin)
    |-> bitClkOut == !con_q[9]) else $error("data changed on wrong edge");
  done_pulse_a: assert property (blockDone |=> !blockDone)
    else $error("block event too long");
  halt_still_a: assert property (settled && con_q[13] && cpuIdle |-> !blockDone && !serialOutPin)
    else $error("runs while halted");
endmodule
bind csi_core csi_asserts i_csi_asserts (.mclk(mclk), .arst_n(arst_n), .cpuIdle(cpuIdle),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .bitClkOut(bitClkOut), .bitClkOe(bitClkOe), .frameSyncOe(frameSyncOe),
  .frameSyncOut(frameSyncOut),
  .serialOutPin(serialOutPin), .serialOutOe(serialOutOe), .blockDone(blockDone));
`default_nettype wire

// >>> dv/csi_codec_model.sv
`timescale 1ns/1ps
`default_nettype none
module csi_codec_model (
  input wire logic run,
  output logic bitClk,
  output logic frameSync,
  output logic serialData
);
  localparam logic [15:0] PATTERN = 16'h5A3C;
  int bitIdx = 0;
  initial begin
    bitClk = 1'b0;
    frameSync = 1'b0;
    serialData = 1'b0;
  end
  // Clock stands still while run is low; the released data line shows the inverse level
  always begin
    if (!run) begin
      bitClk = 1'b0;
      bitIdx = 0;
      serialData = ~serialData;
      wait (run);
    end
    #32 bitClk = 1'b1;
    frameSync = (bitIdx == 0);
    serialData = PATTERN[15 - bitIdx];
    bitIdx = (bitIdx + 1) % 16;
    #32 bitClk = 1'b0;
  end
endmodule
`default_nettype wire

// >>> dv/csi_core_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "csi_regs.vh"
module csi_core_bench;
  logic mclk = 1'b0;
  logic arst_n = 1'b0, clkEn = 1'b1, cpuIdle = 1'b0, run = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, bitClkOut, bitClkOe, frameSyncOut, frameSyncOe;
  logic serialOutPin, serialOutOe, blockDone, codecClk, codecFs, codecData;
  wire bitClkPin = bitClkOe ? bitClkOut : codecClk;
  wire fsPin = frameSyncOe ? frameSyncOut : codecFs;
  int fail_count = 0, tests_run = 0, cyc = 0, n;
  logic [7:0] regA [5] = '{8'h04, 8'h08, 8'h10, 8'h14, 8'h00};
  logic [15:0] regM [5] = '{16'h0DEF, 16'h0FFF, 16'hFFFF, 16'hFFFF, 16'hAFE3};
  logic [15:0] cfg [3] = '{16'h0003, 16'h0C63, 16'h042F};
  int gap [3] = '{24, 96, 192};
  always #2.5 mclk = ~mclk;
  csi_core i_csi_core (.mclk(mclk), .arst_n(arst_n), .clkEn(clkEn), .cpuIdle(cpuIdle),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .bitClkIn(bitClkPin),
    .bitClkOut(bitClkOut), .bitClkOe(bitClkOe), .frameSyncIn(fsPin),
    .frameSyncOut(frameSyncOut), .frameSyncOe(frameSyncOe), .serialInPin(codecData),
    .serialOutPin(serialOutPin), .serialOutOe(serialOutOe), .blockDone(blockDone));
  csi_codec_model i_csi_codec_model (.run(run), .bitClk(codecClk), .frameSync(codecFs),
    .serialData(codecData));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d);
    int k;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    check(32'(k == 20), 32'h0);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 16'h0000);
    check(rd & m, e);
  endtask
  task automatic wait_done(input int lim, output int c);
    c = 0;
    do begin
      @(posedge mclk);
      c++;
    end while (blockDone !== 1'b1 && c < lim);
    if (blockDone !== 1'b1) c = 0;
  endtask
  task automatic blocks(input int k);
    int m;
    repeat (k) begin
      wait_done(3000, m);
      check(32'(m == 0), 32'h0);
    end
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    for (int i = 0; i < 8; i++) rdchk(8'(4 * i), 32'hFFFFFFFF, 32'h0);
    bus(1'b1, `CSI_ADDR_STAT, 16'hFFFF);
    rdchk(`CSI_ADDR_STAT, 32'hFFFFFFFF, 32'h0);
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, regA[i], 16'hFFFF);
      rdchk(regA[i], 32'hFFFFFFFF, {16'h0000, regM[i]});
    end
    bus(1'b0, 8'h40, 16'h0000);
    check({rd[30:0], err}, 32'h1);
    bus(1'b1, 8'h02, 16'h1234);
    check(32'(err), 32'h1);
    bus(1'b1, `CSI_ADDR_DIV, 16'h0002);
    bus(1'b1, `CSI_ADDR_CON2, 16'h000F);
    bus(1'b1, `CSI_ADDR_RXSLOT, 16'h0001);
    bus(1'b1, `CSI_ADDR_TXSLOT, 16'h0001);
    bus(1'b1, 8'h30, 16'hA5C3);
    bus(1'b1, `CSI_ADDR_CON1, 16'h88A0);
    blocks(3);
    rdchk(8'h20, 32'hFFFFFFFF, 32'hA5C3);
    bus(1'b1, `CSI_ADDR_CON2, 16'h0003);
    blocks(3);
    rdchk(8'h20, 32'hFFFFFFFF, 32'hA000);
    bus(1'b1, `CSI_ADDR_CON2, 16'h000F);
    bus(1'b1, `CSI_ADDR_CON1, 16'h8820);
    blocks(4);
    rdchk(`CSI_ADDR_STAT, 32'hFFFFFFFF, 32'h000F);
    rdchk(8'h20, 32'hFFFFFFFF, 32'h0);
    rdchk(`CSI_ADDR_STAT, 32'hFFFFFFFF, 32'h0001);
    bus(1'b1, 8'h30, 16'h1234);
    rdchk(`CSI_ADDR_STAT, 32'h1, 32'h0);
    bus(1'b1, `CSI_ADDR_CON1, 16'hA020);
    cpuIdle <= 1'b1;
    repeat (8) @(posedge mclk);
    wait_done(300, n);
    check(32'(n), 32'h0);
    cpuIdle <= 1'b0;
    blocks(1);
    bus(1'b1, `CSI_ADDR_CON1, 16'h8020);
    bus(1'b1, `CSI_ADDR_RXSLOT, 16'hFFFF);
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, `CSI_ADDR_CON2, cfg[i]);
      blocks(2);
      wait_done(3000, n);
      check(32'(n), 32'(gap[i]));
    end
    bus(1'b1, `CSI_ADDR_TXSLOT, 16'h0000);
    bus(1'b1, `CSI_ADDR_CON2, 16'h000F);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, `CSI_ADDR_CON1, 16'h8020 | 16'(i) | (i[0] ? 16'h0200 : 16'h0000)
        | (i[1] ? 16'h0040 : 16'h0000));
      blocks(2);
    end
    clkEn <= 1'b0;
    wait_done(300, n);
    check(32'(n), 32'h0);
    clkEn <= 1'b1;
    bus(1'b1, `CSI_ADDR_CON1, 16'h8520);
    bus(1'b1, `CSI_ADDR_RXSLOT, 16'h0001);
    run <= 1'b1;
    blocks(4);
    rdchk(8'h20, 32'hFFFFFFFF, 32'h5A3C);
    run <= 1'b0;
    give_verdict();
  end
endmodule
`default_nettype wire
